// ---- crcx_pkg.sv ----
// crcx_pkg: register map, field layout and reset values of the crc engine
`default_nettype none
package crcx_pkg;
  // --------------------------------------------------------------------
  // bus and widths
  // --------------------------------------------------------------------
  localparam int          CRCX_AW      = 8;
  localparam int          CRCX_DW      = 32;
  localparam int          CRCX_LW      = 5;
  localparam logic [4:0]  CRCX_LEN_MAX = 5'h1F;
  localparam logic [31:0] CRCX_ONES    = 32'hFFFF_FFFF;
  localparam logic [31:0] CRCX_POLY_LSB = 32'h0000_0001;
  // --------------------------------------------------------------------
  // register byte addresses
  // --------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_DATA  = 8'h08;
  localparam logic [7:0] ADDR_CHECK = 8'h0C;
  localparam logic [7:0] ADDR_POLY  = 8'h10;
  localparam logic [7:0] ADDR_SHIFT = 8'h14;
  localparam logic [7:0] ADDR_ISTAT = 8'h18;
  localparam logic [7:0] ADDR_IMASK = 8'h1C;
  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_ORDER_BIT = 1;
  localparam int CTRL_AUG_BIT   = 2;
  localparam int CTRL_SRC_BIT   = 3;
  localparam int CTRL_WLEN_LSB  = 8;
  localparam int CTRL_POLY_LENGTH_FIELD_LSB  = 16;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_FULL_BIT  = 1;
  localparam int IRQ_DONE_BIT   = 0;
  // --------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------
  localparam logic [31:0] CTRL_RST  = 32'h001F_0700;
  localparam logic [31:0] POLY_RST  = 32'h0000_0001;
  localparam logic [31:0] SEED_RST  = 32'h0000_0000;
  localparam logic [31:0] DATA_RST  = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h001F_1F0F;
  // --------------------------------------------------------------------
  // engine phases
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    CRCX_IDLE,
    CRCX_DATA,
    CRCX_AUG
  } crcx_phase_t;
endpackage : crcx_pkg
`default_nettype wire

// ---- crcx_shifter.sv ----
// crcx_shifter: xor shift register accumulator, one bit per clock
`default_nettype none
module crcx_shifter (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       reset,
  // word hand-off
  input  wire logic                       start,
  input  wire logic [crcx_pkg::CRCX_DW-1:0] word,
  output logic                            ready,
  // configuration
  input  wire logic [crcx_pkg::CRCX_LW-1:0] wlen,
  input  wire logic [crcx_pkg::CRCX_LW-1:0] poly_length_field,
  input  wire logic [crcx_pkg::CRCX_DW-1:0] poly,
  input  wire logic                       lsb_first,
  input  wire logic                       augment,
  // seed
  input  wire logic                       seed_load,
  input  wire logic [crcx_pkg::CRCX_DW-1:0] seed,
  // state
  output logic [crcx_pkg::CRCX_DW-1:0]    acc,
  output logic [crcx_pkg::CRCX_DW-1:0]    sreg,
  output crcx_pkg::crcx_phase_t           phase,
  output logic [crcx_pkg::CRCX_LW-1:0]    cnt,
  output logic                            busy
);
  import crcx_pkg::*;

  logic [31:0] mask;
  logic [31:0] stepped;
  logic        in_bit;
  logic        last;

  // --------------------------------------------------------------------
  // one division step
  // --------------------------------------------------------------------
  always_comb begin
    mask = CRCX_ONES >> (CRCX_LEN_MAX - poly_length_field);
    if (phase == CRCX_DATA) begin
      in_bit = lsb_first ? sreg[0] : sreg[wlen];
    end else begin
      in_bit = 1'b0;
    end
    stepped = {acc[30:0], in_bit};
    if (acc[poly_length_field]) begin
      stepped = stepped ^ (poly | CRCX_POLY_LSB);
    end
    stepped = stepped & mask;
  end

  assign last  = (cnt == '0);
  assign busy  = (phase != CRCX_IDLE);
  assign ready = (phase == CRCX_IDLE) || (phase == CRCX_AUG && last)
                 || (phase == CRCX_DATA && last && !augment);

  // --------------------------------------------------------------------
  // accumulator
  // --------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      acc <= SEED_RST;
    end else if (seed_load) begin
      acc <= seed & mask;
    end else if (busy) begin
      acc <= stepped;
    end
  end

  // --------------------------------------------------------------------
  // shift stage
  // --------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sreg <= DATA_RST;
    end else if (start) begin
      sreg <= word;
    end else if (phase == CRCX_DATA) begin
      sreg <= lsb_first ? (sreg >> 1) : (sreg << 1);
    end
  end

  // --------------------------------------------------------------------
  // phase sequencer
  // --------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      phase <= CRCX_IDLE;
      cnt   <= '0;
    end else begin
      case (phase)
        CRCX_IDLE: begin
          if (start) begin
            phase <= CRCX_DATA;
            cnt   <= wlen;
          end
        end
        CRCX_DATA: begin
          if (!last) begin
            cnt <= cnt - 5'd1;
          end else if (augment) begin
            phase <= CRCX_AUG;
            cnt   <= poly_length_field;
          end else if (start) begin
            cnt <= wlen;
          end else begin
            phase <= CRCX_IDLE;
          end
        end
        CRCX_AUG: begin
          if (!last) begin
            cnt <= cnt - 5'd1;
          end else if (start) begin
            phase <= CRCX_DATA;
            cnt   <= wlen;
          end else begin
            phase <= CRCX_IDLE;
          end
        end
        default: begin
          phase <= CRCX_IDLE;
        end
      endcase
    end
  end
endmodule : crcx_shifter
`default_nettype wire

// ---- crcx_top.sv ----
// crcx_top: apb register file, data source selection and irq of crc engine
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`default_nettype none
module crcx_top (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        reset,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [crcx_pkg::CRCX_AW-1:0] paddr,
  input  wire logic [crcx_pkg::CRCX_DW-1:0] pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [crcx_pkg::CRCX_DW-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  // memory scanner source
  input  wire logic                        scan_valid,
  input  wire logic [crcx_pkg::CRCX_DW-1:0] scan_word,
  output logic                             scan_ready,
  // interrupt
  output logic                             irq
);
  import crcx_pkg::*;

  logic [31:0] ctrl;
  logic [31:0] poly_tap_reg;
  logic [31:0] data_in_reg;
  logic        full;
  logic        next_full;
  logic        calc_done_flag;
  logic        calc_done_irq_enable;
  logic        busy_q;
  logic [31:0] check_value_reg;
  logic [31:0] shift_stage_reg;
  crcx_phase_t phase;
  logic [4:0]  cnt;
  logic        busy;
  logic        eng_ready;
  logic        take;
  logic        setup;
  logic        access;
  logic        wr;
  logic        hit;
  logic [31:0] rdata;
  logic        cpu_low_write;
  logic        scan_take;
  logic        seed_load;
  logic        busy_fell;

  // --------------------------------------------------------------------
  // apb timing
  // --------------------------------------------------------------------
  assign setup  = psel && penable && !pready;
  assign access = psel && penable && pready;
  assign wr     = access && pwrite;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // --------------------------------------------------------------------
  // address decode and read mux
  // --------------------------------------------------------------------
  always_comb begin
    hit   = 1'b1;
    rdata = '0;
    if (paddr == ADDR_CTRL) begin
      rdata = ctrl;
    end else if (paddr == ADDR_STAT) begin
      rdata[STAT_BUSY_BIT] = busy;
      rdata[STAT_FULL_BIT] = full;
    end else if (paddr == ADDR_DATA) begin
      rdata = data_in_reg;
    end else if (paddr == ADDR_CHECK) begin
      rdata = check_value_reg;
    end else if (paddr == ADDR_POLY) begin
      rdata = poly_tap_reg | CRCX_POLY_LSB;
    end else if (paddr == ADDR_SHIFT) begin
      rdata = shift_stage_reg;
    end else if (paddr == ADDR_ISTAT) begin
      rdata[IRQ_DONE_BIT] = calc_done_flag;
    end else if (paddr == ADDR_IMASK) begin
      rdata[IRQ_DONE_BIT] = calc_done_irq_enable;
    end else begin
      hit = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // apb answer
  // --------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hit;
      if (setup && !pwrite) begin
        prdata <= rdata;
      end
    end
  end

  // --------------------------------------------------------------------
  // control and polynomial registers
  // --------------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl <= CTRL_RST;
    end else if (wr && paddr == ADDR_CTRL) begin
      ctrl <= merge(ctrl, pwdata, pstrb) & CTRL_MASK;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      poly_tap_reg <= POLY_RST;
    end else if (wr && paddr == ADDR_POLY) begin
      poly_tap_reg <= merge(poly_tap_reg, pwdata, pstrb) | CRCX_POLY_LSB;
    end
  end

  // --------------------------------------------------------------------
  // data register and source selection
  // --------------------------------------------------------------------
  // low byte lane starts
  assign cpu_low_write = wr && paddr == ADDR_DATA && pstrb[0]
                         && !ctrl[CTRL_SRC_BIT];
  assign scan_take = scan_valid && scan_ready;
  assign take      = full && ctrl[CTRL_GO_BIT] && eng_ready;
  assign next_full = cpu_low_write || scan_take || (full && !take);

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      data_in_reg <= DATA_RST;
    end else if (scan_take) begin
      data_in_reg <= scan_word;
    end else if (wr && paddr == ADDR_DATA && !ctrl[CTRL_SRC_BIT]) begin
      data_in_reg <= merge(data_in_reg, pwdata, pstrb);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      full       <= 1'b0;
      scan_ready <= 1'b0;
    end else begin
      full       <= next_full;
      scan_ready <= ctrl[CTRL_SRC_BIT] && ctrl[CTRL_GO_BIT] && !next_full;
    end
  end

  assign seed_load = wr && paddr == ADDR_CHECK && !busy;

  // --------------------------------------------------------------------
  // shift engine
  // --------------------------------------------------------------------
  crcx_shifter u_shift (
    .mclk      (mclk),
    .reset     (reset),
    .start     (take),
    .word      (data_in_reg),
    .ready     (eng_ready),
    .wlen      (ctrl[CTRL_WLEN_LSB +: CRCX_LW]),
    .poly_length_field      (ctrl[CTRL_POLY_LENGTH_FIELD_LSB +: CRCX_LW]),
    .poly      (poly_tap_reg),
    .lsb_first (ctrl[CTRL_ORDER_BIT]),
    .augment   (ctrl[CTRL_AUG_BIT]),
    .seed_load (seed_load),
    .seed      (merge(check_value_reg, pwdata, pstrb)),
    .acc       (check_value_reg),
    .sreg      (shift_stage_reg),
    .phase     (phase),
    .cnt       (cnt),
    .busy      (busy)
  );

  // --------------------------------------------------------------------
  // completion interrupt
  // --------------------------------------------------------------------
  assign busy_fell = busy_q && !busy;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      calc_done_flag <= 1'b0;
    end else if (busy_fell) begin
      calc_done_flag <= 1'b1;
    end else if (wr && paddr == ADDR_ISTAT && pstrb[0] && pwdata[IRQ_DONE_BIT]) begin
      calc_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      calc_done_irq_enable <= 1'b0;
    end else if (wr && paddr == ADDR_IMASK && pstrb[0]) begin
      calc_done_irq_enable <= pwdata[IRQ_DONE_BIT];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= calc_done_flag && calc_done_irq_enable;
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  AST_WIDTH_MASK: assert property (
    busy || seed_load |=> (check_value_reg
      & ~(CRCX_ONES >> (CRCX_LEN_MAX - $past(ctrl[CTRL_POLY_LENGTH_FIELD_LSB +: CRCX_LW])))) == '0)
    else $error("accumulator bits above polynomial length set");

  AST_FULL_WIDTH: assert property (
    busy && ctrl[CTRL_POLY_LENGTH_FIELD_LSB +: CRCX_LW] == 5'h1F && check_value_reg[31]
      |=> check_value_reg[0] != $past(u_shift.in_bit))
    else $error("32 bit feedback did not xor forced low term");

  AST_AUG_FEED: assert property (
    phase == CRCX_AUG && check_value_reg[ctrl[CTRL_POLY_LENGTH_FIELD_LSB +: CRCX_LW]]
      |=> check_value_reg[0])
    else $error("forced low polynomial term missing in feedback");

  AST_POLY_READ: assert property (
    setup && !pwrite && paddr == ADDR_POLY |=> prdata[0] && pready)
    else $error("polynomial bit zero did not read as one");

  AST_HELD_FULL: assert property (
    full && !take |=> full)
    else $error("pending word lost before engine took it");

  AST_LOW_START: assert property (
    cpu_low_write |=> full)
    else $error("low byte write did not mark word pending");

  AST_BIT_STEP: assert property (
    busy && cnt != '0 |=> cnt == $past(cnt) - 5'd1)
    else $error("engine did not advance one bit per clock");

  AST_NO_AUG_END: assert property (
    phase == CRCX_DATA && cnt == '0 && !ctrl[CTRL_AUG_BIT] && !take
      |=> phase == CRCX_IDLE)
    else $error("calculation continued past data without augmentation");

  AST_AUG_LEN: assert property (
    phase == CRCX_DATA && cnt == '0 && ctrl[CTRL_AUG_BIT]
      |=> phase == CRCX_AUG && cnt == $past(ctrl[CTRL_POLY_LENGTH_FIELD_LSB +: CRCX_LW]))
    else $error("augmentation did not load polynomial length");

  AST_DONE_FLAG: assert property (
    busy_q && !busy |=> calc_done_flag)
    else $error("busy fall did not set done flag");

  AST_IRQ_LEVEL: assert property (
    irq == ($past(calc_done_flag) && $past(calc_done_irq_enable)))
    else $error("interrupt does not follow unmasked done flag");

  AST_UNMAPPED: assert property (
    setup && !hit |=> pslverr && pready)
    else $error("unmapped access not answered with error");

  AST_SCAN_GATE: assert property (
    scan_ready |-> !full && $past(ctrl[CTRL_SRC_BIT] && ctrl[CTRL_GO_BIT]))
    else $error("scanner offered a slot while word pending or not selected");

  AST_WORD_LOAD: assert property (
    take |=> busy && cnt == $past(ctrl[CTRL_WLEN_LSB +: CRCX_LW]))
    else $error("word start did not load word length count");

  AST_IDLE_STILL: assert property (
    !busy && !seed_load |=> $stable(check_value_reg))
    else $error("accumulator moved while engine idle");

  AST_CHECK_READ: assert property (
    setup && !pwrite && paddr == ADDR_CHECK |=> prdata == $past(check_value_reg))
    else $error("check value read did not return accumulator");

  AST_STAT_READ: assert property (
    setup && !pwrite && paddr == ADDR_STAT |=> prdata[STAT_FULL_BIT] == $past(full))
    else $error("status read did not return pending word flag");

  // --------------------------------------------------------------------
  // scenario covers
  // --------------------------------------------------------------------
  COV_WORD: cover property (take ##1 busy);
  COV_AUG: cover property (phase == CRCX_AUG ##1 phase == CRCX_IDLE);
  COV_SCAN: cover property (scan_take ##[1:40] busy_fell);
  COV_IRQ: cover property (busy_fell ##2 irq);
  COV_HELD: cover property (full && busy ##1 take);
endmodule : crcx_top
`default_nettype wire

// ---- crcx_scan_model.sv ----
// crcx_scan_model: memory scanner stand-in feeding words to the crc engine
`default_nettype none
module crcx_scan_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // behaviour
  input  wire logic        slow,
  // scanner port
  input  wire logic        scan_ready,
  output logic             scan_valid,
  output logic [31:0]      scan_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] q[$];
  int          gap;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      scan_valid <= 1'b0;
      scan_word  <= 32'h0000_0000;
      gap        <= 0;
    end else if (scan_valid && scan_ready) begin
      scan_valid <= 1'b0;
      scan_word  <= ~scan_word;
      gap        <= slow ? $urandom_range(5, 0) : 0;
    end else if (!scan_valid && gap > 0) begin
      gap       <= gap - 1;
      scan_word <= ~scan_word;
    end else if (!scan_valid && q.size() > 0) begin
      scan_word  <= q.pop_front();
      scan_valid <= 1'b1;
    end else if (!scan_valid) begin
      scan_word <= ~scan_word;
    end
  end
endmodule : crcx_scan_model
`default_nettype wire

// ---- configurable_crc_engine_test.sv ----
// configurable_crc_engine_test: self-checking bench of the crc engine
`default_nettype none
module configurable_crc_engine_test;
  timeunit 1ns;
  timeprecision 1ps;
  import crcx_pkg::*;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scan_valid;
  logic [31:0] scan_word;
  logic        scan_ready;
  logic        irq;
  logic        slow = 1'b0;
  int          mismatches = 0;
  int          comparisons = 0;
  always #25 mclk = ~mclk;
  crcx_top u_dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scan_valid(scan_valid), .scan_word(scan_word),
    .scan_ready(scan_ready), .irq(irq));
  crcx_scan_model u_scan (.mclk(mclk), .reset(reset), .slow(slow),
    .scan_ready(scan_ready), .scan_valid(scan_valid), .scan_word(scan_word));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic stop_test;
    $display("counts: %0d mismatches, %0d comparisons", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic er);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      chk(32'h0, 32'h1, "pready timeout");
      stop_test();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, s, rd, er);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic er;
    apb(1'b0, a, 32'h0000_0000, 4'h0, d, er);
  endtask : rd
  task automatic wait_clear(input logic [31:0] m);
    logic [31:0] st;
    int          n;
    for (n = 0; n < 100; n++) begin
      rd(ADDR_STAT, st);
      if ((st & m) === 32'h0000_0000) break;
    end
    if (n == 100) begin
      chk(32'h0, 32'h1, "engine stuck");
      stop_test();
    end
  endtask : wait_clear
  function automatic logic [31:0] ctl(logic go, logic o, logic g, logic s,
                                      logic [4:0] wl, logic [4:0] pl);
    return {11'h000, pl, 3'h0, wl, 4'h0, s, g, o, go};
  endfunction : ctl
  function automatic logic [31:0] crc_ref(logic [31:0] a, logic [31:0] w, logic [4:0] wl,
                                          logic [4:0] pl, logic [31:0] p, logic o, logic g);
    logic [31:0] m;
    logic        b;
    logic        f;
    int          i;
    int          n;
    m = 32'((33'h1 << (int'(pl) + 1)) - 33'h1);
    n = int'(wl) + 1 + (g ? int'(pl) + 1 : 0);
    for (i = 0; i < n; i++) begin
      b = (i > int'(wl)) ? 1'b0 : (o ? w[i] : w[int'(wl) - i]);
      f = a[pl];
      a = (((a << 1) | 32'(b)) ^ (f ? (p | 32'h0000_0001) : 32'h0000_0000)) & m;
    end
    return a;
  endfunction : crc_ref
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  logic [31:0] d, e, p, sd, w, w2, m;
  logic [4:0]  pl, wl;
  logic        o, g, er;
  int          k, j, n0, n1, n2;
  logic [7:0]  ra[6] = '{ADDR_CTRL, ADDR_STAT, ADDR_CHECK, ADDR_POLY, ADDR_ISTAT, ADDR_IMASK};
  logic [31:0] rv[6] = '{CTRL_RST, 32'h0, 32'h0, POLY_RST, 32'h0, 32'h0};
  initial begin
    void'($urandom(24464));
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    for (k = 0; k < 6; k++) begin
      rd(ra[k], d);
      chk(d, rv[k], "reset value");
    end
    apb(1'b0, 8'h20, 32'h0, 4'h0, d, er);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(d, 32'h0, "unmapped data");
    wr(ADDR_POLY, 32'h0000_0000, 4'hF);
    rd(ADDR_POLY, d);
    chk(d, 32'h0000_0001, "poly bit zero");
    // known crc32 example, zeros appended by hand
    wr(ADDR_POLY, 32'h04C1_1DB6, 4'hF);
    rd(ADDR_POLY, d);
    chk(d, 32'h04C1_1DB7, "poly readback");
    wr(ADDR_CTRL, ctl(1, 0, 0, 0, 5'd7, 5'd31), 4'hF);
    chk({31'h0, scan_ready}, 32'h0, "scanner held off");
    for (k = 0; k < 8; k++) begin
      wait_clear(32'h2);
      wr(ADDR_DATA, (k < 4) ? 32'(8'h55 + 8'h11 * k) : 32'h0, 4'h1);
    end
    wait_clear(32'h3);
    rd(ADDR_CHECK, d);
    chk(d, 32'hC60D_8323, "crc32 example");
    rd(ADDR_ISTAT, d);
    chk(d, 32'h1, "done flag unmasked");
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(ADDR_ISTAT, 32'h1, 4'hF);
    // random configurations and words
    for (k = 0; k < 6; k++) begin
      pl = (k == 0) ? 5'd31 : 5'($urandom_range(31, 3));
      wl = (k == 0) ? 5'd31 : 5'($urandom_range(31, 0));
      o  = 1'($urandom_range(1, 0));
      g  = (k < 2) ? 1'(k) : 1'($urandom_range(1, 0));
      p  = $urandom & 32'hFFFF_FFFE;
      m  = 32'((33'h1 << (int'(pl) + 1)) - 33'h1);
      sd = $urandom & m;
      wr(ADDR_CTRL, ctl(0, o, g, 0, wl, pl), 4'hF);
      wr(ADDR_POLY, p, 4'hF);
      wr(ADDR_CHECK, sd, 4'hF);
      wr(ADDR_CTRL, ctl(1, o, g, 0, wl, pl), 4'hF);
      e = sd;
      for (j = 0; j < 3; j++) begin
        w = $urandom;
        wait_clear(32'h2);
        wr(ADDR_DATA, w, 4'hE);
        wr(ADDR_DATA, w, 4'h1);
        e = crc_ref(e, w, wl, pl, p, o, g);
      end
      wait_clear(32'h3);
      rd(ADDR_CHECK, d);
      chk(d, e, "random check value");
    end
    // word held while the previous one shifts
    wr(ADDR_CTRL, ctl(0, 0, 0, 0, 5'd31, 5'd31), 4'hF);
    wr(ADDR_CHECK, 32'hFFFF_FFFF, 4'hF);
    wr(ADDR_CTRL, ctl(1, 0, 0, 0, 5'd31, 5'd31), 4'hF);
    w  = $urandom;
    w2 = $urandom;
    wr(ADDR_DATA, w, 4'hF);
    wr(ADDR_DATA, w2, 4'hF);
    rd(ADDR_STAT, d);
    chk(d & 32'h3, 32'h3, "busy and full");
    wait_clear(32'h3);
    e = crc_ref(crc_ref(32'hFFFF_FFFF, w, 5'd31, 5'd31, p, 0, 0), w2, 5'd31, 5'd31, p, 0, 0);
    rd(ADDR_CHECK, d);
    chk(d, e, "held word");
    // irq latency against word length and augmentation
    wr(ADDR_ISTAT, 32'h1, 4'hF);
    wr(ADDR_IMASK, 32'h1, 4'hF);
    lat(5'd7, 0, n0);
    lat(5'd7, 1, n1);
    lat(5'd15, 0, n2);
    chk(32'(n1 - n0), 32'd16, "augment cycles");
    chk(32'(n2 - n0), 32'd8, "data cycles");
    rd(ADDR_ISTAT, d);
    chk(d, 32'h0, "flag cleared");
    chk({31'h0, irq}, 32'h0, "irq cleared");
    // scanner source, cpu data ignored
    slow <= 1'b1;
    wr(ADDR_CTRL, ctl(0, 1, 0, 0, 5'd15, 5'd15), 4'hF);
    wr(ADDR_CHECK, 32'h0000_1D0F, 4'hF);
    wr(ADDR_CTRL, ctl(1, 1, 0, 1, 5'd15, 5'd15), 4'hF);
    wr(ADDR_DATA, 32'h1234_5678, 4'hF);
    e = 32'h0000_1D0F;
    for (j = 0; j < 4; j++) begin
      w = $urandom;
      u_scan.q.push_back(w);
      e = crc_ref(e, w, 5'd15, 5'd15, p, 1, 0);
    end
    for (j = 0; j < 300 && (u_scan.q.size() > 0 || scan_valid === 1'b1); j++)
      @(posedge mclk);
    if (j == 300) begin
      chk(32'h0, 32'h1, "scanner stuck");
      stop_test();
    end
    wait_clear(32'h3);
    rd(ADDR_CHECK, d);
    chk(d, e, "scanner check value");
    stop_test();
  end
  task automatic lat(input logic [4:0] wl, input logic g, output int n);
    wr(ADDR_CTRL, ctl(1, 0, g, 0, wl, 5'd15), 4'hF);
    wr(ADDR_DATA, $urandom, 4'hF);
    for (n = 0; n < 200 && irq !== 1'b1; n++)
      @(posedge mclk);
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(ADDR_ISTAT, 32'h1, 4'hF);
  endtask : lat
endmodule : configurable_crc_engine_test
`default_nettype wire
